/* File: shared/erib_map.svh */
// Register indices, field positions, reset values and timing constants
`ifndef ERIB_MAP_SVH
`define ERIB_MAP_SVH

// Register indices; the byte address is four times the index
`define ERIB_IDX_CTRL       4'h0
`define ERIB_IDX_TLIMIT     4'h1
`define ERIB_IDX_SPDCAP     4'h2
`define ERIB_IDX_ACCEL      4'h3
`define ERIB_IDX_DECEL      4'h4
`define ERIB_IDX_ILKFAST    4'h5
`define ERIB_IDX_ILKSLOW    4'h6
`define ERIB_IDX_ILKTMO     4'h7
`define ERIB_IDX_HSTHR      4'h8
`define ERIB_IDX_SETTHR     4'h9
`define ERIB_IDX_SEQDLY     4'ha
`define ERIB_IDX_STATUS     4'hb
`define ERIB_NUM_CFG        11

// Control register fields
`define ERIB_CTRL_EN        0
`define ERIB_CTRL_SRC       1
`define ERIB_CTRL_CLR       2
`define ERIB_CTRL_ILKEN     3
`define ERIB_CTRL_KIND_LO   4
`define ERIB_CTRL_KIND_HI   5
`define ERIB_CTRL_SWON      8
`define ERIB_CTRL_SWOFF     9

// Reset values of the stored registers
`define ERIB_RST_CTRL       16'h0000
`define ERIB_RST_TLIMIT     16'h0ea6
`define ERIB_RST_SPDCAP     16'h03e8
`define ERIB_RST_RAMP       16'h03e8
`define ERIB_RST_ILKTMO     16'h0000
`define ERIB_RST_HSTHR      16'h07d0
`define ERIB_RST_SETTHR     16'h0064
`define ERIB_RST_SEQDLY     16'h0064

// Time limit value that means no timeout, and brake kinds that use one
`define ERIB_TLIMIT_NONE    12'hea6
`define ERIB_KIND_ONE       2'h1
`define ERIB_KIND_TWO       2'h2

// Base tick of one millisecond at the 40 MHz clock; slow tick is 8 ms
`define ERIB_CLK_HZ         40000000
`define ERIB_TICK_US        1000
`define ERIB_SLOW_DIV       3'h7

`endif

/* File: shared/erib_pkg.sv */
// Types shared by the interlock and emergency reverse supervisor
package erib_pkg;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_EMR     = 3'b001,
    ST_RELEASE = 3'b010,
    ST_ILKBRK  = 3'b011,
    ST_ILKSEQ  = 3'b100,
    ST_COAST   = 3'b101
  } erib_state_t;

  // Command to the drive: target speed, ramp count, bridge and brake
  typedef struct packed {
    logic signed [15:0] targetSpeed;
    logic [15:0]        rampCount;
    logic               bridgeOn;
    logic               mechBrakeOn;
  } erib_cmd_t;

  // Operator pins after synchronisation
  typedef struct packed {
    logic emrSwitch;
    logic interlock;
    logic throttle;
    logic direction;
  } erib_pins_t;

endpackage : erib_pkg

/* File: hw/erib_core.sv */
// Emergency reverse and interlock braking supervisor with APB registers
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "erib_map.svh"

// Operation
// RL1 - Reverse requests are ignored while the function enable is off.
// RL2 - Request comes from the switch pin when source is 0, software when 1.
// RL3 - Clear setting on: interlock, throttle and direction must release.
// RL4 - Clear setting off: only throttle and direction must release afterwards.
// RL5 - Reverse motion time is limited by a 0 to 3750 count, 8 ms each.
// RL6 - The maximum limit value means no timeout at all.
// RL7 - Forward motion during emergency reverse restarts the time limit timer.
// RL8 - Expiry of the time limit sets the timeout fault flag.
// RL9 - Releasing and reasserting the request clears the timeout fault.
// RL10 - A zero limit only stops the vehicle, never drives it backward.
// RL11 - Reverse speed is held to the programmed cap in emergency reverse.
// RL12 - After stopping, reverse acceleration uses the programmed accel ramp.
// RL13 - Reverse motion below the cap is raised to it with the accel ramp.
// RL14 - Forward motion is braked to a stop with the decel ramp.
// RL15 - Reverse motion above the cap is lowered to it with the decel ramp.
// RL16 - Interlock braking on: regen stops the vehicle on interlock removal.
// RL17 - Interlock braking off: bridge turns off after the sequencing delay.
// RL18 - At high speed, interlock braking uses the fast-speed ramp.
// RL19 - At low speed, interlock braking uses the separate slow-speed ramp.
// RL20 - Interlock brake timer, 0 to 1000 counts, starts at interlock removal.
// RL21 - Timer expiry above the set-speed threshold engages the mech brake.
// RL22 - Regen braking continues together with the engaged mechanical brake.
// RL23 - Interlock brake timeout applies only for brake kind 1 or 2.
// RL24 - All timers and ramps count on a fixed periodic control tick.
module erib_core #(
  parameter int unsigned TICK_CYCLES = (`ERIB_CLK_HZ / 1000000) * `ERIB_TICK_US
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire erib_pkg::erib_pins_t pinsRaw,
  input  wire logic signed [15:0] motorSpeed,
  output erib_pkg::erib_cmd_t     driveCmd,
  output logic                    emrActive,
  output logic                    emrTimeoutFault,
  output logic                    driveAllowed
);
  import erib_pkg::*;

  // ==========================================================================
  // Helper functions
  // ==========================================================================
  // Magnitude of a signed speed, saturating the most negative value
  function automatic logic [15:0] absSpeed(input logic signed [15:0] s);
    logic [15:0] r;
    r = s[15] ? 16'(-s) : 16'(s);
    if (r[15])
      r = 16'h7fff;
    return r;
  endfunction : absSpeed

  // Address decode: index of a mapped register, valid flag in bit 4
  function automatic logic [4:0] decodeAddr(input logic [11:0] a);
    logic [4:0] r;
    r = 5'h00;
    if (a[11:6] != 6'h00 || a[1:0] != 2'h0)
      r = 5'h00;
    else if (a[5:2] <= `ERIB_IDX_STATUS)
      r = {1'b1, a[5:2]};
    else
      r = 5'h00;
    return r;
  endfunction : decodeAddr

  // Reset value of each stored register
  function automatic logic [15:0] resetVal(input int idx);
    logic [15:0] r;
    r = `ERIB_RST_RAMP;
    if (idx == int'(`ERIB_IDX_CTRL))
      r = `ERIB_RST_CTRL;
    else if (idx == int'(`ERIB_IDX_TLIMIT))
      r = `ERIB_RST_TLIMIT;
    else if (idx == int'(`ERIB_IDX_SPDCAP))
      r = `ERIB_RST_SPDCAP;
    else if (idx == int'(`ERIB_IDX_ILKTMO))
      r = `ERIB_RST_ILKTMO;
    else if (idx == int'(`ERIB_IDX_HSTHR))
      r = `ERIB_RST_HSTHR;
    else if (idx == int'(`ERIB_IDX_SETTHR))
      r = `ERIB_RST_SETTHR;
    else if (idx == int'(`ERIB_IDX_SEQDLY))
      r = `ERIB_RST_SEQDLY;
    return r;
  endfunction : resetVal

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [3:0]  pinMeta_reg;
  logic [3:0]  pinSync_reg;
  erib_pins_t  pins;

  // Two flops per operator pin; only the second stage is read
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      pinMeta_reg <= 4'h0;
      pinSync_reg <= 4'h0;
    end
    else
    begin
      pinMeta_reg <= pinsRaw;
      pinSync_reg <= pinMeta_reg;
    end

  assign pins = erib_pins_t'(pinSync_reg);

  // ==========================================================================
  // APB register file
  // ==========================================================================
  logic [15:0] cfgReg [0:`ERIB_NUM_CFG-1];
  logic [15:0] statusWord;
  logic [4:0]  dec;
  logic        wrEn;
  logic        swOn_reg;

  assign dec     = decodeAddr(paddr);
  assign wrEn    = psel && penable && pwrite && dec[4]
                   && dec[3:0] != `ERIB_IDX_STATUS;
  assign pready  = 1'b1;  // Zero wait states; read data latched at setup
  assign pslverr = psel && penable && !dec[4];

  // Stored configuration words, one generated slot per register
  for (genvar g = 0; g < `ERIB_NUM_CFG; g++)
  begin : gCfg
    always_ff @(posedge clk or negedge resetn)
      if (!resetn)
        cfgReg[g] <= resetVal(g);
      else if (wrEn && dec[3:0] == 4'(g))
        cfgReg[g] <= pwdata[15:0];
  end

  // Read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
    begin
      if (!dec[4])
        prdata <= 32'h0000_0000;
      else if (dec[3:0] == `ERIB_IDX_STATUS)
        prdata <= {16'h0000, statusWord};
      else if (dec[3:0] == `ERIB_IDX_CTRL)
        prdata <= {26'h0000000, cfgReg[dec[3:0]][`ERIB_CTRL_KIND_HI:0]};
      else
        prdata <= {16'h0000, cfgReg[dec[3:0]]};
    end

  // Configuration fields
  logic        cfgEn;
  logic        cfgSrc;
  logic        cfgClr;
  logic        cfgIlkEn;
  logic [1:0]  cfgKind;
  logic [11:0] tLimit;
  logic [15:0] spdCap;
  logic [9:0]  ilkTmo;
  logic        kindOk;

  assign cfgEn    = cfgReg[`ERIB_IDX_CTRL][`ERIB_CTRL_EN];
  assign cfgSrc   = cfgReg[`ERIB_IDX_CTRL][`ERIB_CTRL_SRC];
  assign cfgClr   = cfgReg[`ERIB_IDX_CTRL][`ERIB_CTRL_CLR];
  assign cfgIlkEn = cfgReg[`ERIB_IDX_CTRL][`ERIB_CTRL_ILKEN];
  assign cfgKind  = cfgReg[`ERIB_IDX_CTRL][`ERIB_CTRL_KIND_HI:
                                           `ERIB_CTRL_KIND_LO];
  assign tLimit   = cfgReg[`ERIB_IDX_TLIMIT][11:0];
  assign spdCap   = cfgReg[`ERIB_IDX_SPDCAP];
  assign ilkTmo   = cfgReg[`ERIB_IDX_ILKTMO][9:0];
  assign kindOk   = cfgKind == `ERIB_KIND_ONE
                    || cfgKind == `ERIB_KIND_TWO;  // [RL23]

  // Software request: enable and disable commands are write pulses
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      swOn_reg <= 1'b0;
    else if (wrEn && dec[3:0] == `ERIB_IDX_CTRL)
    begin
      if (pwdata[`ERIB_CTRL_SWON])
        swOn_reg <= 1'b1;
      else if (pwdata[`ERIB_CTRL_SWOFF])
        swOn_reg <= 1'b0;
    end

  // ==========================================================================
  // Control tick dividers
  // ==========================================================================
  logic [31:0] tickCnt_reg;
  logic [2:0]  slowCnt_reg;
  logic        tick;
  logic        slowTick;

  // One millisecond base tick and an eight millisecond slow tick
  always_ff @(posedge clk or negedge resetn)  // [RL24]
    if (!resetn)
    begin
      tickCnt_reg <= 32'h0000_0000;
      slowCnt_reg <= 3'h0;
    end
    else if (tick)
    begin
      tickCnt_reg <= 32'h0000_0000;
      slowCnt_reg <= slowCnt_reg + 3'h1;
    end
    else
      tickCnt_reg <= tickCnt_reg + 32'h0000_0001;

  assign tick     = tickCnt_reg == 32'(TICK_CYCLES - 1);
  assign slowTick = tick && slowCnt_reg == `ERIB_SLOW_DIV;

  // ==========================================================================
  // Request selection and state machine
  // ==========================================================================
  erib_state_t state_reg;
  erib_state_t state_next;
  logic        emrReq;
  logic        emrReqDly_reg;
  logic        emrRise;
  logic        fault_reg;
  logic        tlExpire;
  logic        seqDone;
  logic        released;

  // Source selector picks pin or software; enable gates both
  assign emrReq  = cfgEn && (cfgSrc ? swOn_reg : pins.emrSwitch); // [RL1][RL2]
  assign emrRise = emrReq && !emrReqDly_reg;
  // Interlock must also drop only when the clear setting asks for it
  assign released = !pins.throttle && !pins.direction
                    && (!cfgClr || !pins.interlock);  // [RL3][RL4]

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (emrReq)
          state_next = ST_EMR;
        else if (!pins.interlock)
          state_next = cfgIlkEn ? ST_ILKBRK : ST_ILKSEQ;  // [RL16][RL17]
      ST_EMR:
        if (!emrReq)
          state_next = ST_RELEASE;
      ST_RELEASE:
        if (emrReq)
          state_next = ST_EMR;
        else if (released)
          state_next = ST_IDLE;
      ST_ILKBRK:
        if (emrReq)
          state_next = ST_EMR;
        else if (pins.interlock)
          state_next = ST_IDLE;
      ST_ILKSEQ:
        if (pins.interlock)
          state_next = ST_IDLE;
        else if (seqDone)
          state_next = ST_COAST;
      ST_COAST:
        if (pins.interlock)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      state_reg     <= ST_IDLE;
      emrReqDly_reg <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      emrReqDly_reg <= emrReq;
    end

  // ==========================================================================
  // Emergency reverse time limit and fault
  // ==========================================================================
  logic [11:0] emrCnt_reg;

  // Counts slow ticks while moving backward; forward motion restarts it
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      emrCnt_reg <= 12'h000;
    else if (state_reg != ST_EMR || motorSpeed > 16'sd0)
      emrCnt_reg <= 12'h000;  // [RL7]
    else if (motorSpeed < 16'sd0 && slowTick && emrCnt_reg != tLimit)
      emrCnt_reg <= emrCnt_reg + 12'h001;  // [RL5]

  // Zero limit is stop-only, so only nonzero finite limits raise the fault
  assign tlExpire = state_reg == ST_EMR && emrCnt_reg == tLimit
                    && tLimit != 12'h000
                    && tLimit != `ERIB_TLIMIT_NONE;  // [RL6]

  // Set wins over the clear made by a fresh request edge
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      fault_reg <= 1'b0;
    else if (tlExpire)
      fault_reg <= 1'b1;  // [RL8]
    else if (emrRise)
      fault_reg <= 1'b0;  // [RL9]

  // ==========================================================================
  // Interlock braking timers
  // ==========================================================================
  logic [15:0] ilkCnt_reg;
  logic        ilkTimedOut_reg;
  logic [15:0] spdAbs;

  assign spdAbs  = absSpeed(motorSpeed);
  assign seqDone = ilkCnt_reg >= cfgReg[`ERIB_IDX_SEQDLY];

  // Restarted on every state change, so it starts at interlock removal
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      ilkCnt_reg <= 16'h0000;
    else if (state_next != state_reg)
      ilkCnt_reg <= 16'h0000;  // [RL20]
    else if (ilkCnt_reg != 16'hffff
             && ((state_reg == ST_ILKBRK && slowTick)
                 || (state_reg == ST_ILKSEQ && tick)))
      ilkCnt_reg <= ilkCnt_reg + 16'h0001;

  // Brake latch holds for the rest of the braking event
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      ilkTimedOut_reg <= 1'b0;
    else if (state_reg != ST_ILKBRK)
      ilkTimedOut_reg <= 1'b0;
    else if (kindOk && ilkCnt_reg >= 16'(ilkTmo)
             && spdAbs >= cfgReg[`ERIB_IDX_SETTHR])
      ilkTimedOut_reg <= 1'b1;  // [RL21][RL23]

  // ==========================================================================
  // Drive command
  // ==========================================================================
  erib_cmd_t cmd_next;
  erib_cmd_t cmd_reg;
  logic      stopOnly;

  assign stopOnly = tLimit == 12'h000 || fault_reg;  // [RL10]

  always_comb
  begin
    cmd_next = '{targetSpeed: 16'sd0,
                 rampCount:   cfgReg[`ERIB_IDX_DECEL],
                 bridgeOn:    1'b1,
                 mechBrakeOn: 1'b0};
    case (state_reg)
      ST_EMR:
      begin
        if (!stopOnly)
          cmd_next.targetSpeed = -$signed(spdCap);  // [RL11]
        // Forward, too fast backward or stop-only brakes; otherwise ramp up
        if (!stopOnly && motorSpeed <= 16'sd0
            && spdAbs <= spdCap)
          cmd_next.rampCount = cfgReg[`ERIB_IDX_ACCEL];  // [RL12][RL13]
        else
          cmd_next.rampCount = cfgReg[`ERIB_IDX_DECEL];  // [RL14][RL15]
      end
      ST_ILKBRK:
      begin
        if (spdAbs > cfgReg[`ERIB_IDX_HSTHR])
          cmd_next.rampCount = cfgReg[`ERIB_IDX_ILKFAST];  // [RL18]
        else
          cmd_next.rampCount = cfgReg[`ERIB_IDX_ILKSLOW];  // [RL19]
        // Regen stays on beside the mechanical brake
        cmd_next.mechBrakeOn = ilkTimedOut_reg;  // [RL22]
      end
      ST_COAST:
        cmd_next.bridgeOn = 1'b0;  // [RL17]
      default:
        cmd_next.rampCount = cfgReg[`ERIB_IDX_DECEL];
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      cmd_reg <= '0;
    else
      cmd_reg <= cmd_next;

  assign driveCmd        = cmd_reg;
  assign emrActive       = state_reg == ST_EMR;
  assign emrTimeoutFault = fault_reg;
  assign driveAllowed    = state_reg == ST_IDLE && pins.interlock;
  assign statusWord      = {10'h000, ilkTimedOut_reg, swOn_reg,
                            fault_reg, state_reg};

  // ==========================================================================
  // Assertions
  // ==========================================================================
  disabled_ignore_a: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == ST_IDLE && !cfgEn |=> state_reg != ST_EMR)  // [RL1]
    else $error("reverse entered while function disabled");

  pin_source_a: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == ST_IDLE && cfgEn && !cfgSrc && pins.emrSwitch
    |=> state_reg == ST_EMR)  // [RL2]
    else $error("switch request not taken");

  clear_interlock_a: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == ST_RELEASE && cfgClr && pins.interlock
    |=> state_reg != ST_IDLE)  // [RL3]
    else $error("drive resumed with interlock still set");

  clear_short_a: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == ST_RELEASE && !cfgClr && !emrReq && !pins.throttle
    && !pins.direction |=> state_reg == ST_IDLE)  // [RL4]
    else $error("drive not resumed after release");

  forward_restart_a: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == ST_EMR && motorSpeed > 16'sd0
    |=> emrCnt_reg == 12'h000)  // [RL7]
    else $error("time limit not restarted by forward motion");

  fault_set_a: assert property (@(posedge clk) disable iff (!resetn)
    tlExpire |=> fault_reg ##1 (fault_reg || $past(emrRise)))  // [RL8]
    else $error("timeout fault not set");

  no_timeout_a: assert property (@(posedge clk) disable iff (!resetn)
    tLimit == `ERIB_TLIMIT_NONE && !fault_reg |=> !fault_reg)  // [RL6]
    else $error("fault with unlimited time");

  stop_only_a: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == ST_EMR && tLimit == 12'h000
    |=> cmd_reg.targetSpeed == 16'sd0)  // [RL10]
    else $error("reverse driven with zero limit");

  coast_off_a: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == ST_COAST ##1 state_reg == ST_COAST
    |-> !cmd_reg.bridgeOn)  // [RL17]
    else $error("bridge on while coasting");

  brake_kind_a: assert property (@(posedge clk) disable iff (!resetn)
    cmd_reg.mechBrakeOn |-> $past(kindOk, 2) && cmd_reg.bridgeOn)  // [RL23]
    else $error("brake engaged for wrong kind");

endmodule : erib_core

/* File: testbench/erib_motor_model.sv */
// Motor and bridge stand-in: speed follows the drive command
`timescale 1ns/1ps
module erib_motor_model (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire erib_pkg::erib_cmd_t driveCmd,
  input  wire logic                holdEn,
  input  wire logic signed [15:0]  holdVal,
  output logic signed [15:0]       motorSpeed
);
  import erib_pkg::*;
  // ==========================================================
  // Speed update
  // A bridge that is off lets the vehicle coast, so forward speed decays and reverse speed holds
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      motorSpeed <= 16'sh0;
    else if (holdEn)
      motorSpeed <= holdVal;
    else if (driveCmd.bridgeOn && motorSpeed < driveCmd.targetSpeed)
      motorSpeed <= motorSpeed + 16'sh4;
    else if (driveCmd.bridgeOn && motorSpeed > driveCmd.targetSpeed)
      motorSpeed <= motorSpeed - 16'sh4;
    else if (!driveCmd.bridgeOn && motorSpeed > 16'sh0)
      motorSpeed <= motorSpeed - 16'sh1;
  end
endmodule : erib_motor_model

/* File: testbench/erib_core_tb_top.sv */
// Self-checking bench for the reverse and interlock supervisor
`timescale 1ns/1ps
`include "erib_map.svh"
module erib_core_tb_top;
  import erib_pkg::*;
  // ==========================================================
  // Bench signals
  logic               clk = 1'b0;
  logic               resetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [11:0]        paddr = 12'h0;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               emrActive;
  logic               emrTimeoutFault;
  logic               driveAllowed;
  logic               holdEn = 1'b1;
  logic signed [15:0] holdVal = 16'sh0;
  logic signed [15:0] motorSpeed;
  erib_pins_t         pins = 4'h4;
  erib_cmd_t          cmd;
  logic [31:0]        rd;
  logic               err;
  int                 errorCnt = 0;
  int                 checksDone = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  erib_core #(.TICK_CYCLES(20)) dut (.clk(clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pinsRaw(pins), .motorSpeed(motorSpeed), .driveCmd(cmd),
    .emrActive(emrActive), .emrTimeoutFault(emrTimeoutFault),
    .driveAllowed(driveAllowed));

  erib_motor_model motor (.clk(clk), .resetn(resetn), .driveCmd(cmd),
    .holdEn(holdEn), .holdVal(holdVal), .motorSpeed(motorSpeed));

  // ==========================================================
  // Shared tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic closeOut();
    $display("Checks %0d, mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : closeOut

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checksDone++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk

  // Request held until pready is seen high; bounded wait
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 50)
    begin
      errorCnt++;
      closeOut();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [3:0] i, input logic [15:0] v);
    apb(1'b1, {6'h0, i, 2'h0}, {16'h0, v});
  endtask : wr

  // Interlock present, other pins released, after the pin synchroniser
  task automatic rst();
    resetn <= 1'b0;
    pins <= 4'h4;
    cyc(10);
    resetn <= 1'b1;
    cyc(3);
  endtask : rst

  // ==========================================================
  // Scenarios
  task automatic tRegs();
    logic [3:0]  idx [4] = '{4'h0, 4'h1, 4'h2, 4'h9};
    logic [15:0] val [4] = '{16'h0, 16'h0ea6, 16'h03e8, 16'h0064};
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, {6'h0, idx[i], 2'h0}, 32'h0);
      chk(rd, {16'h0, val[i]}, "reset value");
    end
    apb(1'b0, 12'h030, 32'h0);
    chk(32'(err), 32'h1, "unmapped error");
  endtask : tRegs

  task automatic tRamps();
    logic [15:0] spd [3] = '{16'h01f4, 16'hff38, 16'hfc7c};
    logic [15:0] rmp [3] = '{16'h0190, 16'h012c, 16'h0190};
    wr(`ERIB_IDX_SPDCAP, 16'h0258);
    wr(`ERIB_IDX_ACCEL, 16'h012c);
    wr(`ERIB_IDX_DECEL, 16'h0190);
    pins.emrSwitch <= 1'b1;
    cyc(6);
    chk(32'(emrActive), 32'h0, "disabled request");
    pins.emrSwitch <= 1'b0;
    wr(`ERIB_IDX_CTRL, 16'h0001);
    // Forward, slow reverse and fast reverse against a 600 rpm cap
    for (int i = 0; i < 3; i++)
    begin
      holdVal <= spd[i];
      pins.emrSwitch <= 1'b1;
      cyc(5);
      chk(32'(emrActive), 32'h1, "pin request");
      chk(32'(cmd.targetSpeed), 32'hfffffda8, "reverse cap");
      chk(32'(cmd.rampCount), {16'h0, rmp[i]}, "ramp");
      pins.emrSwitch <= 1'b0;
      cyc(6);
    end
  endtask : tRamps

  task automatic tSoft();
    rst();
    wr(`ERIB_IDX_CTRL, 16'h0003);
    pins.emrSwitch <= 1'b1;
    cyc(6);
    chk(32'(emrActive), 32'h0, "pin ignored");
    pins.emrSwitch <= 1'b0;
    wr(`ERIB_IDX_CTRL, 16'h0103);
    cyc(2);
    chk(32'(emrActive), 32'h1, "soft on");
    wr(`ERIB_IDX_CTRL, 16'h0203);
    cyc(2);
    chk(32'(emrActive), 32'h0, "soft off");
  endtask : tSoft

  // Limit of 3 slow ticks expires 320 to 480 cycles into reverse motion
  task automatic tLimit();
    rst();
    wr(`ERIB_IDX_CTRL, 16'h0001);
    wr(`ERIB_IDX_TLIMIT, 16'h0003);
    holdVal <= 16'hff38;
    pins.emrSwitch <= 1'b1;
    cyc(300);
    chk(32'(emrTimeoutFault), 32'h0, "early fault");
    holdVal <= 16'h00c8;
    cyc(30);
    holdVal <= 16'hff38;
    // Past the point where a merely paused timer would already expire
    cyc(360);
    chk(32'(emrTimeoutFault), 32'h0, "no restart");
    cyc(250);
    chk(32'(emrTimeoutFault), 32'h1, "no fault");
    // Status: state code of reverse with the fault bit set
    apb(1'b0, {6'h0, `ERIB_IDX_STATUS, 2'h0}, 32'h0);
    chk(rd, 32'h0000_0009, "status word");
    pins.emrSwitch <= 1'b0; // Operator cycles the request
    cyc(5);
    pins.emrSwitch <= 1'b1;
    cyc(5);
    chk(32'(emrTimeoutFault), 32'h0, "fault kept");
    pins.emrSwitch <= 1'b0;
    wr(`ERIB_IDX_TLIMIT, 16'h0000);
    pins.emrSwitch <= 1'b1;
    cyc(6);
    chk(32'(cmd.targetSpeed), 32'h0, "zero limit");
  endtask : tLimit

  task automatic tClear();
    rst();
    wr(`ERIB_IDX_CTRL, 16'h0005);
    pins.emrSwitch <= 1'b1;
    pins.throttle <= 1'b1;
    cyc(5);
    pins.emrSwitch <= 1'b0;
    cyc(5);
    chk(32'(driveAllowed), 32'h0, "throttle held");
    pins.throttle <= 1'b0;
    cyc(5);
    chk(32'(driveAllowed), 32'h0, "interlock uncycled");
    pins.interlock <= 1'b0;
    cyc(5);
    pins.interlock <= 1'b1;
    cyc(5);
    chk(32'(driveAllowed), 32'h1, "all released");
    wr(`ERIB_IDX_CTRL, 16'h0001);
    pins.emrSwitch <= 1'b1;
    pins.direction <= 1'b1;
    cyc(5);
    pins.emrSwitch <= 1'b0;
    cyc(5);
    chk(32'(driveAllowed), 32'h0, "direction held");
    pins.direction <= 1'b0;
    cyc(5);
    chk(32'(driveAllowed), 32'h1, "released");
  endtask : tClear

  // Brake kinds 0, 1 and 2 at 3000 rpm; timeout of one 160-cycle unit
  task automatic tIlk();
    for (int k = 0; k < 3; k++)
    begin
      rst();
      wr(`ERIB_IDX_CTRL, {10'h0, 2'(k), 4'h8});
      wr(`ERIB_IDX_ILKTMO, 16'h0001);
      wr(`ERIB_IDX_ILKFAST, 16'h01f4);
      holdVal <= 16'h0bb8;
      pins.interlock <= 1'b0;
      cyc(6);
      chk(32'(cmd.bridgeOn), 32'h1, "regen on");
      chk(32'(cmd.rampCount), 32'h1f4, "fast ramp");
      chk(32'(cmd.mechBrakeOn), 32'h0, "early brake");
      cyc(400);
      chk(32'(cmd.mechBrakeOn), 32'(k != 0), "brake");
      chk(32'(cmd.bridgeOn), 32'h1, "regen kept");
    end
  endtask : tIlk

  task automatic tSlow();
    rst();
    wr(`ERIB_IDX_CTRL, 16'h0008);
    wr(`ERIB_IDX_ILKSLOW, 16'h02bc);
    holdVal <= 16'h03e8;
    pins.interlock <= 1'b0;
    cyc(6);
    chk(32'(cmd.rampCount), 32'h2bc, "slow ramp");
    rst();
    wr(`ERIB_IDX_SEQDLY, 16'h0002);
    holdEn <= 1'b0;
    pins.interlock <= 1'b0;
    cyc(10);
    chk(32'(cmd.bridgeOn), 32'h1, "bridge early off");
    cyc(60);
    chk(32'(cmd.bridgeOn), 32'h0, "bridge still on");
  endtask : tSlow

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    rst();
    tRegs();
    tRamps();
    tSoft();
    tLimit();
    tClear();
    tIlk();
    tSlow();
    closeOut();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    closeOut();
  end
endmodule : erib_core_tb_top
